// *** rtl/cpl_pkg.sv ***
// Constants, register map and mode encoding of the CAN transceiver control
package cpl_pkg;

   // Clock and timing
   localparam int CLK_PERIOD_NS     = 5;
   localparam int REC_RELEASE_NS    = 1000;
   localparam int REC_RELEASE_CYC   =
      (REC_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DOM_TIMEOUT_NS    = 2000000;
   localparam int DOM_TIMEOUT_CYC   = DOM_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int CNT_W             = 20;

   // Register indices; byte address is four times the index
   localparam logic [3:0] IDX_PORT_PIN_DATA  = 4'h0;
   localparam logic [3:0] IDX_XCVR_CONTROL   = 4'h1;
   localparam logic [3:0] IDX_FACTORY_TEST_A = 4'h2;
   localparam logic [3:0] IDX_XCVR_STATUS    = 4'h3;
   localparam logic [3:0] IDX_FACTORY_TEST_B = 4'h4;
   localparam logic [3:0] IDX_FACTORY_TEST_C = 4'h5;
   localparam logic [3:0] IDX_FAULT_IRQ_EN   = 4'h6;
   localparam logic [3:0] IDX_FAULT_IRQ_FLAG = 4'h7;
   localparam logic [3:0] IDX_MODE_CONFIG    = 4'h8;

   // Field positions
   localparam int PD_WAKE_RX    = 7;
   localparam int PD_SOFT_TX    = 1;
   localparam int PD_RX         = 0;
   localparam int CR_ENABLE     = 7;
   localparam int CR_TERM       = 6;
   localparam int CR_WAKE       = 5;
   localparam int ST_TIMEOUT    = 3;
   localparam int IE_VOLTAGE    = 4;
   localparam int IE_TIMEOUT    = 3;
   localparam int IE_OVERCUR    = 0;
   localparam int MC_ROUTE_SOFT = 2;

   // Writable masks and reset values
   localparam logic [7:0] CR_RW_MASK   = 8'he7;
   localparam logic [7:0] CR_RESET     = 8'h20;
   localparam logic [7:0] IE_RW_MASK   = 8'h19;
   localparam logic [7:0] FLAG_MASK    = 8'hfb;
   localparam logic [7:0] MC_RW_MASK   = 8'h07;
   localparam logic [7:0] MC_RESET     = 8'h00;
   localparam logic [7:0] SYNC_RESET   = 8'h03;

   // Requested operating mode codes in the mode config register
   localparam logic [1:0] REQ_NORMAL  = 2'h0;
   localparam logic [1:0] REQ_PSEUDO  = 2'h1;
   localparam logic [1:0] REQ_LISTEN  = 2'h2;
   localparam logic [1:0] REQ_STANDBY = 2'h3;

   // Operating modes, one-hot
   typedef enum logic [4:0] {
      MODE_SHUTDOWN = 5'h01,
      MODE_NORMAL   = 5'h02,
      MODE_PSEUDO   = 5'h04,
      MODE_LISTEN   = 5'h08,
      MODE_STANDBY  = 5'h10
   } cpl_mode_type;

endpackage : cpl_pkg

// *** rtl/cpl_phy_ctrl.sv ***
// Digital mode control, bit path and registers of the CAN transceiver
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/100ps

// Function
// - Transmit input high means recessive, low means dominant.
// - Receive output high for recessive bus, low for dominant bus.
// - Standby routes wake receiver to receive output; else precision rx.
// - Port data bit 7 reads synchronized wake receiver, read-only.
// - When routed, port data bit 1 drives the transmit bit directly.
// - Port data bit 0 reads synchronized receive output, read-only.
// - Port data register reads and writes are allowed in every mode.
// - Shutdown removes all bias, wake receiver included.
// - Normal mode fully biased; termination biased only when enabled.
// - Pseudo-normal equals normal with low-side driver and termination bias disabled.
// - Listen-only equals normal with transmitter de-biased, never drives.
// - Standby fully de-biased; wake receiver enable set after reset.
// - Nine byte registers at base plus offsets zero to eight.
// - Control bit 7 sets once and moves shutdown to the requested mode.
// - Control bit 6 biases termination in normal and listen-only.
// - Control bit 5 enables wake receiver in all modes but shutdown.
// - Timeout status sets on long dominant, clears after 1 us recessive.
module cpl_phy_ctrl #(
   parameter int DOM_TIMEOUT_CYC = cpl_pkg::DOM_TIMEOUT_CYC
) (
   // Clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Protocol controller bit lines
   input  wire logic        phy_tx_bit_in,
   output logic             phy_rx_bit_out,
   // Analog receivers and monitors
   input  wire logic        precise_rx_in,
   input  wire logic        wake_rx_in,
   input  wire logic [3:0]  line_voltage_fault_in,
   input  wire logic [1:0]  line_overcurrent_in,
   // Analog bias and driver controls
   output logic             rx_bias_en,
   output logic             tx_bias_en,
   output logic             high_driver_en,
   output logic             low_driver_en,
   output logic             tx_drive_dominant,
   output logic             wake_rx_en,
   output logic             term_bias_en,
   output logic      [2:0]  edge_rate_select,
   // Interrupt
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0]             sync1_r;
   logic [7:0]             sync2_r;
   logic [7:0]             sync_prev_r;
   logic [7:0]             ctrl_r;
   logic [7:0]             ie_r;
   logic [7:0]             flags_r;
   logic [7:0]             mcfg_r;
   logic                   soft_tx_r;
   logic                   ack_r;
   logic [31:0]            rdata_r;
   logic                   rx_out_r;
   logic                   timeout_r;
   logic                   ts_prev_r;
   logic [cpl_pkg::CNT_W-1:0] dom_cnt_r;
   logic [cpl_pkg::CNT_W-1:0] rec_cnt_r;
   cpl_pkg::cpl_mode_type  mode;
   logic                   bus_req;
   logic                   wr_go;
   logic                   rd_go;
   logic                   tx_bit;
   logic                   prec_s;
   logic                   wake_s;
   logic [3:0]             volt_s;
   logic [1:0]             oc_s;
   logic [7:0]             status;
   logic [7:0]             flag_set;
   logic [7:0]             rd_byte;

   // Width-exact constants for counter compares
   localparam logic [cpl_pkg::CNT_W-1:0] DOM_LIMIT =
      cpl_pkg::CNT_W'(DOM_TIMEOUT_CYC);
   localparam logic [cpl_pkg::CNT_W-1:0] REC_LIMIT =
      cpl_pkg::CNT_W'(cpl_pkg::REC_RELEASE_CYC);

   // Saturating increment, shared by both timers
   function automatic logic [cpl_pkg::CNT_W-1:0] sat_inc(
      input logic [cpl_pkg::CNT_W-1:0] v);
      sat_inc = (&v) ? v : v + 1'b1;
   endfunction

   // Byte-masked register update
   function automatic logic [7:0] wr_merge(
      input logic [7:0] old,
      input logic [7:0] din,
      input logic [7:0] mask);
      wr_merge = (old & ~mask) | (din & mask);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers for the analog receivers and monitors

   // Only stage two and beyond are read by logic
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sync1_r     <= cpl_pkg::SYNC_RESET;
         sync2_r     <= cpl_pkg::SYNC_RESET;
         sync_prev_r <= cpl_pkg::SYNC_RESET;
      end else if (clk_en) begin
         sync1_r     <= {line_overcurrent_in, line_voltage_fault_in,
                         wake_rx_in, precise_rx_in};
         sync2_r     <= sync1_r;
         sync_prev_r <= sync2_r;
      end
   end

   assign prec_s = sync2_r[0];
   assign wake_s = sync2_r[1];
   assign volt_s = sync2_r[5:2];
   assign oc_s   = sync2_r[7:6];

   ////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait cycle, then the answer

   assign bus_req         = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~(ack_r & clk_en);  // Stall when frozen
   assign wr_go           = clk_en & avs_write & ack_r & avs_byteenable[0];
   assign rd_go           = clk_en & avs_read & ~ack_r;

   // Ack toggles so each request completes after one wait cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else if (clk_en) begin
         ack_r <= bus_req & ~ack_r;
      end
   end

   // Read decode; unmapped and factory-test offsets read as zero
   always_comb begin
      rd_byte = 8'h00;
      unique case (avs_address)
         cpl_pkg::IDX_PORT_PIN_DATA: begin
            rd_byte[cpl_pkg::PD_WAKE_RX] = wake_s;
            rd_byte[cpl_pkg::PD_SOFT_TX] = soft_tx_r;
            rd_byte[cpl_pkg::PD_RX]      = rx_out_r;
         end
         cpl_pkg::IDX_XCVR_CONTROL:   rd_byte = ctrl_r;
         cpl_pkg::IDX_XCVR_STATUS:    rd_byte = status;
         cpl_pkg::IDX_FAULT_IRQ_EN:   rd_byte = ie_r;
         cpl_pkg::IDX_FAULT_IRQ_FLAG: rd_byte = flags_r;
         cpl_pkg::IDX_MODE_CONFIG:    rd_byte = mcfg_r;
         default:                     rd_byte = 8'h00;
      endcase
   end

   // Read data captured at the wait edge and held through the answer
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (rd_go) begin
         rdata_r <= {24'h00_0000, rd_byte};
      end
   end

   assign avs_readdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // Software-written registers

   // Enable bit is sticky: a zero write cannot return to shutdown
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_r <= cpl_pkg::CR_RESET;
      end else if (wr_go && avs_address == cpl_pkg::IDX_XCVR_CONTROL) begin
         ctrl_r <= wr_merge(ctrl_r, avs_writedata[7:0],
                            cpl_pkg::CR_RW_MASK);
         ctrl_r[cpl_pkg::CR_ENABLE] <= ctrl_r[cpl_pkg::CR_ENABLE]
                                     | avs_writedata[cpl_pkg::CR_ENABLE];
      end
   end

   // Soft transmit bit, written in any mode
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         soft_tx_r <= 1'b1;
      end else if (wr_go && avs_address == cpl_pkg::IDX_PORT_PIN_DATA) begin
         soft_tx_r <= avs_writedata[cpl_pkg::PD_SOFT_TX];
      end
   end

   // Interrupt enables and mode configuration
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ie_r   <= 8'h00;
         mcfg_r <= cpl_pkg::MC_RESET;
      end else if (wr_go) begin
         if (avs_address == cpl_pkg::IDX_FAULT_IRQ_EN) begin
            ie_r <= wr_merge(ie_r, avs_writedata[7:0],
                             cpl_pkg::IE_RW_MASK);
         end
         if (avs_address == cpl_pkg::IDX_MODE_CONFIG) begin
            mcfg_r <= wr_merge(mcfg_r, avs_writedata[7:0],
                               cpl_pkg::MC_RW_MASK);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode selection and bias controls
   // Shutdown until enabled, then the requested mode
   always_comb begin
      if (!ctrl_r[cpl_pkg::CR_ENABLE]) begin
         mode = cpl_pkg::MODE_SHUTDOWN;
      end else begin
         unique case (mcfg_r[1:0])
            cpl_pkg::REQ_NORMAL:  mode = cpl_pkg::MODE_NORMAL;
            cpl_pkg::REQ_PSEUDO:  mode = cpl_pkg::MODE_PSEUDO;
            cpl_pkg::REQ_LISTEN:  mode = cpl_pkg::MODE_LISTEN;
            cpl_pkg::REQ_STANDBY: mode = cpl_pkg::MODE_STANDBY;
         endcase
      end
   end

   // Receiver biased in every active mode; standby and shutdown de-bias
   assign rx_bias_en = (mode == cpl_pkg::MODE_NORMAL)
                     | (mode == cpl_pkg::MODE_PSEUDO)
                     | (mode == cpl_pkg::MODE_LISTEN);
   // Listen-only keeps the transmitter de-biased
   assign tx_bias_en = (mode == cpl_pkg::MODE_NORMAL)
                     | (mode == cpl_pkg::MODE_PSEUDO);
   assign high_driver_en = tx_bias_en;
   assign low_driver_en  = (mode == cpl_pkg::MODE_NORMAL);
   // Wake receiver follows control bit 5, forced off in shutdown
   assign wake_rx_en = ctrl_r[cpl_pkg::CR_WAKE]
                     & (mode != cpl_pkg::MODE_SHUTDOWN);
   assign term_bias_en = ctrl_r[cpl_pkg::CR_TERM]
                       & ((mode == cpl_pkg::MODE_NORMAL)
                        | (mode == cpl_pkg::MODE_LISTEN));
   assign edge_rate_select = ctrl_r[2:0];

   ////////////////////////////////////////////////////////////////////////
   // Transmit path and dominant timeout
   // Soft route lets software hold the line without the controller
   assign tx_bit = mcfg_r[cpl_pkg::MC_ROUTE_SOFT] ? soft_tx_r
                                                  : phy_tx_bit_in;

   // A stuck dominant input is cut off until it has rested recessive
   assign tx_drive_dominant = tx_bias_en & ~tx_bit & ~timeout_r;

   // Counters of dominant and recessive run length
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dom_cnt_r <= '0;
         rec_cnt_r <= '0;
      end else if (clk_en) begin
         dom_cnt_r <= tx_bit ? '0 : sat_inc(dom_cnt_r);
         rec_cnt_r <= tx_bit ? sat_inc(rec_cnt_r) : '0;
      end
   end

   // Timeout status: set after the limit, cleared after 1 us recessive
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         timeout_r <= 1'b0;
      end else if (clk_en) begin
         if (!tx_bit && dom_cnt_r >= DOM_LIMIT) begin
            timeout_r <= 1'b1;
         end else if (tx_bit && rec_cnt_r >= REC_LIMIT) begin
            timeout_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive path
   // Registered output; recessive high, dominant low as the receivers give
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rx_out_r <= 1'b1;
      end else if (clk_en) begin
         rx_out_r <= (mode == cpl_pkg::MODE_STANDBY) ? wake_s
                                                     : prec_s;
      end
   end

   assign phy_rx_bit_out = rx_out_r;

   ////////////////////////////////////////////////////////////////////////
   // Status, sticky flags and interrupt
   assign status = {volt_s, timeout_r, 3'h0};

   // Flags catch rising edges of each fault level
   assign flag_set = {volt_s & ~sync_prev_r[5:2],
                      timeout_r & ~ts_prev_r, 1'b0,
                      oc_s & ~sync_prev_r[7:6]};

   // Previous timeout state for edge detection
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ts_prev_r <= 1'b0;
      end else if (clk_en) begin
         ts_prev_r <= timeout_r;
      end
   end

   // Set wins over a simultaneous write-one clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         flags_r <= 8'h00;
      end else if (clk_en) begin
         flags_r <= ((flags_r & ~((wr_go &&
                       avs_address == cpl_pkg::IDX_FAULT_IRQ_FLAG)
                       ? avs_writedata[7:0] : 8'h00)) | flag_set)
                    & cpl_pkg::FLAG_MASK;
      end
   end

   assign irq = (ie_r[cpl_pkg::IE_VOLTAGE] & (|flags_r[7:4]))
              | (ie_r[cpl_pkg::IE_TIMEOUT] & flags_r[3])
              | (ie_r[cpl_pkg::IE_OVERCUR] & (|flags_r[1:0]));

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_port_write;
      wr_go && avs_address == cpl_pkg::IDX_PORT_PIN_DATA;
   endsequence

   property p_tx_polarity;
      tx_drive_dominant |-> !tx_bit && tx_bias_en;
   endproperty
   a_tx_polarity: assert property (p_tx_polarity)
      else $error("dominant driven while transmit bit recessive");
   property p_rx_route;
      clk_en |=> phy_rx_bit_out ==
         ($past(mode) == cpl_pkg::MODE_STANDBY ? $past(wake_s)
                                               : $past(prec_s));
   endproperty
   a_rx_route: assert property (p_rx_route)
      else $error("receive output from wrong receiver");
   property p_soft_write;
      s_port_write |=> soft_tx_r == $past(avs_writedata[cpl_pkg::PD_SOFT_TX]);
   endproperty
   a_soft_write: assert property (p_soft_write)
      else $error("port data write not taken");
   property p_shutdown;
      mode == cpl_pkg::MODE_SHUTDOWN |->
         !rx_bias_en && !tx_bias_en && !wake_rx_en && !term_bias_en;
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("bias present in shutdown");
   property p_listen;
      mode == cpl_pkg::MODE_LISTEN |-> !tx_drive_dominant && rx_bias_en;
   endproperty
   a_listen: assert property (p_listen)
      else $error("bus driven in listen-only");
   property p_pseudo;
      mode == cpl_pkg::MODE_PSEUDO |-> !low_driver_en && high_driver_en;
   endproperty
   a_pseudo: assert property (p_pseudo)
      else $error("low driver active in pseudo-normal");
   property p_standby;
      mode == cpl_pkg::MODE_STANDBY |->
         !rx_bias_en && !tx_bias_en && wake_rx_en == ctrl_r[cpl_pkg::CR_WAKE];
   endproperty
   a_standby: assert property (p_standby)
      else $error("standby bias wrong");
   property p_enable_once;
      ctrl_r[cpl_pkg::CR_ENABLE] |=> ctrl_r[cpl_pkg::CR_ENABLE];
   endproperty
   a_enable_once: assert property (p_enable_once)
      else $error("enable bit cleared after set");
   property p_term;
      mode == cpl_pkg::MODE_NORMAL |->
         term_bias_en == ctrl_r[cpl_pkg::CR_TERM];
   endproperty
   a_term: assert property (p_term)
      else $error("termination bias mismatch");
   property p_timeout_hold;
      clk_en && timeout_r && !tx_bit |=> timeout_r;
   endproperty
   a_timeout_hold: assert property (p_timeout_hold)
      else $error("timeout cleared while dominant");

endmodule // cpl_phy_ctrl

// *** tb/cpl_ctrl_model.sv ***
// Protocol controller transmit bit model for the transceiver bench
`timescale 1ns/100ps
module cpl_ctrl_model (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Bench command: hold the line dominant
   input  wire logic send_dom,
   // Transmit bit towards the transceiver
   output logic      tx_bit
);
   // Idle is recessive high; a dominant bit is a low level
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tx_bit <= 1'b1;
      end else begin
         tx_bit <= ~send_dom;
      end
   end
endmodule // cpl_ctrl_model

// *** tb/tb_top.sv ***
// Self-checking bench of the transceiver control block
`timescale 1ns/100ps
module tb_top;
   logic        core_clk = 1'b0;
   logic        rst_n    = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        send_dom = 1'b0;
   logic        tx_bit;
   logic        rx_out;
   logic        precise_rx = 1'b1;
   logic        wake_rx = 1'b1;
   logic [3:0]  volt_flt = 4'h0;
   logic [1:0]  over_cur = 2'h0;
   logic        rx_b, tx_b, hi_d, lo_d, dom, wk_en, term, irq;
   int          miscompares = 0;
   int          check_count = 0;
   int          cycles = 0;
   logic [31:0] q;
   logic [2:0]  er;

   // 200 MHz clock
   always #2.5 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////
   // Device, protocol controller model and bus loopback
   cpl_phy_ctrl #(.DOM_TIMEOUT_CYC(50)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .phy_tx_bit_in(tx_bit),
      .phy_rx_bit_out(rx_out), .precise_rx_in(precise_rx),
      .wake_rx_in(wake_rx), .line_voltage_fault_in(volt_flt),
      .line_overcurrent_in(over_cur), .rx_bias_en(rx_b),
      .tx_bias_en(tx_b), .high_driver_en(hi_d), .low_driver_en(lo_d),
      .tx_drive_dominant(dom), .wake_rx_en(wk_en),
      .term_bias_en(term), .edge_rate_select(er), .irq(irq));
   cpl_ctrl_model partner (.core_clk(core_clk), .rst_n(rst_n),
      .send_dom(send_dom), .tx_bit(tx_bit));
   // Bus wire seen by the precision receiver follows the driver
   always @(posedge core_clk) precise_rx <= ~dom;

   ////////////////////////////////////////////////////////////////////
   // Checking, bus tasks and closing report
   task automatic complete_run;
      if (miscompares == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One access; held until waitrequest is sampled low at an edge
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [7:0] d);
      @(posedge core_clk);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= {24'h0, d};
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e,
                     input string what);
      bus(1'b0, a, 8'h00);
      check(what, q, {24'h0, e});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Hang guard, well above the expected run length
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      cyc(5);
      rst_n <= 1'b1;
      rd(4'h1, 8'h20, "control reset");
      rd(4'h0, 8'h83, "port reset");
      check("shutdown bias", {rx_b, tx_b, wk_en, term}, 0);
      wr(4'h2, 8'hff);
      rd(4'h2, 8'h00, "reserved");
      rd(4'h9, 8'h00, "unmapped");
      wr(4'h0, 8'h00);
      rd(4'h0, 8'h81, "port soft");
      wr(4'h0, 8'h02);
      wr(4'h1, 8'he0);
      cyc(1);
      check("normal", {rx_b, tx_b, hi_d, lo_d, wk_en, term}, 6'h3f);
      wr(4'h1, 8'h00);
      rd(4'h1, 8'h80, "enable once");
      check("wake, term off", {wk_en, term}, 0);
      wr(4'h1, 8'h66);
      // Dominant round trip through the loopback
      send_dom <= 1'b1;
      cyc(8);
      check("drive dominant", dom, 1);
      check("rx dominant", rx_out, 0);
      check("edge rate", er, 3'h6);
      rd(4'h0, 8'h82, "rx readback");
      send_dom <= 1'b0;
      cyc(8);
      check("rx recessive", rx_out, 1);
      wr(4'h8, 8'h01);
      cyc(1);
      check("pseudo", {tx_b, lo_d}, 2'b10);
      wr(4'h8, 8'h02);
      cyc(1);
      check("listen", {rx_b, tx_b, term}, 3'b101);
      wr(4'h8, 8'h03);
      cyc(1);
      check("standby", {rx_b, tx_b, wk_en}, 3'b001);
      wake_rx <= 1'b0;
      cyc(8);
      check("standby rx", rx_out, 0);
      rd(4'h0, 8'h02, "wake readback");
      wake_rx <= 1'b1;
      // Software-driven transmit bit
      wr(4'h8, 8'h04);
      wr(4'h0, 8'h00);
      cyc(1);
      check("soft dominant", dom, 1);
      wr(4'h0, 8'h02);
      cyc(1);
      check("soft recessive", dom, 0);
      wr(4'h8, 8'h00);
      // Interrupt: raise, mask, clear
      wr(4'h6, 8'h19);
      over_cur <= 2'h1;
      cyc(4);
      over_cur <= 2'h0;
      cyc(4);
      rd(4'h7, 8'h01, "overcurrent flag");
      check("irq set", irq, 1);
      wr(4'h6, 8'h00);
      cyc(1);
      check("irq masked", irq, 0);
      wr(4'h6, 8'h19);
      wr(4'h7, 8'h01);
      rd(4'h7, 8'h00, "flag cleared");
      check("irq cleared", irq, 0);
      volt_flt <= 4'h8;
      cyc(6);
      rd(4'h3, 8'h80, "voltage status");
      volt_flt <= 4'h0;
      rd(4'h7, 8'h80, "voltage flag");
      wr(4'h7, 8'hff);
      // Dominant timeout and its release after 200 recessive cycles
      send_dom <= 1'b1;
      cyc(60);
      check("timeout block", dom, 0);
      rd(4'h3, 8'h08, "timeout set");
      rd(4'h7, 8'h08, "timeout flag");
      check("timeout irq", irq, 1);
      send_dom <= 1'b0;
      cyc(100);
      rd(4'h3, 8'h08, "timeout held");
      cyc(120);
      rd(4'h3, 8'h00, "timeout clear");
      complete_run();
   end
endmodule // tb_top
